// File: rss_regs.vh
// Constants for the reference selection and switchover block.
// Assumes a plain register port with read data one cycle after the strobe.
// What this block and its host do
// RULE1 - Auto revertive: always use highest priority valid input, switch at once.
// RULE2 - Auto non-revertive: keep current input until it goes invalid.
// RULE3 - Manual modes take the choice from register or selection pins.
// RULE4 - Manual fallback: chosen input while valid, else best valid input.
// RULE5 - Fallback with nothing valid: holdover if history valid, else free-run.
// RULE6 - Manual holdover: no fallback; holdover if history valid, else free-run.
// RULE7 - Manual modes resume tracking once the chosen input is valid again.
// RULE8 - Hitless off: full phase offset passes through at loop bandwidth rate.
// RULE9 - Cancellation without slew keeps the absorbed offset indefinitely; the code still slews it off after switches that are not frequency-locked.
// RULE10 - Frequency-locked means equal or integer-related input frequencies.
// RULE11 - Slew enable removes buildout in bounded steps at a set interval.
// RULE12 - Slew limits also apply on acquisition entry and unlocked switches.
// RULE13 - Hitless pulse-per-second switching only with zero-delay sync off.
// RULE14 - Host switches pulse-per-second inputs only after lock, else soft reset.
// RULE15 - Gapped inputs locked to; gap at most one divided reference period.
// RULE16 - Host sets monitor thresholds so gapping raises no flags.
// RULE17 - Input valid only after monitors stay clear for validation time.
// RULE18 - Equal priority ties go to the lower input index.
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
`define RSS_REG_CTRL 4'h0
`define RSS_REG_PRIO 4'h1
`define RSS_REG_VTIME 4'h2
`define RSS_REG_SLEW 4'h3
`define RSS_REG_FGRP 4'h4
`define RSS_REG_STAT 4'h5
`define RSS_REG_IRQ_STAT 4'h6
`define RSS_REG_IRQ_MASK 4'h7
`define RSS_REG_BUILDOUT 4'h8
`define RSS_CTRL_MODE_LSB 0
`define RSS_CTRL_MAN_LSB 2
`define RSS_CTRL_PIN_SEL 4
`define RSS_CTRL_HIST_VALID 5
`define RSS_CTRL_HITLESS 6
`define RSS_CTRL_SLEW_EN 7
`define RSS_CTRL_ZDS 8
`define RSS_CTRL_PPS 9
`define RSS_CTRL_RESET 16'h0000
`define RSS_PRIO_RESET 16'hE4E4
`define RSS_VTIME_RESET 16'h0010
`define RSS_SLEW_RESET 16'h1004
`define RSS_FGRP_RESET 16'h0000
`define RSS_MODE_AUTO_REV 2'h0
`define RSS_MODE_AUTO_NREV 2'h1
`define RSS_MODE_MAN_FALL 2'h2
`define RSS_MODE_MAN_HOLD 2'h3
`define RSS_ST_FREE 2'h0
`define RSS_ST_HOLD 2'h1
`define RSS_ST_TRACK 2'h2
`define RSS_IRQ_SWITCH 0
`define RSS_IRQ_HOLD 1
`define RSS_IRQ_FREE 2
`define RSS_IRQ_INVALID 3
`endif

// File: rss_validator.v
// One input validation timer: flag-free time before the input is usable.
// Assumes monitor flags already synchronised to core_clk_in.
`timescale 1ns/1ps
module rss_validator #(
  parameter CW = 16
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire flag_in,
  input wire [CW-1:0] vtime_in,
  output reg valid_out
);
  reg [CW-1:0] count;

  // Any flag restarts the full qualification period
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= {CW{1'b0}};
      valid_out <= 1'b0;
    end else if (flag_in) begin
      count <= {CW{1'b0}};
      valid_out <= 1'b0;
    end else if (count >= vtime_in) begin
      valid_out <= 1'b1; // RULE17
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: rss_select.v
// Reference selection, holdover and hitless switchover control for one loop.
// Assumes monitor flags and selection pins are asynchronous to core_clk_in,
// and that the phase detector delivers a signed offset on the same clock.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_select #(
  parameter N = 4,
  parameter PW = 16
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  input wire [N-1:0] monitor_flag_in,
  input wire [1:0] select_pins_in,
  input wire loop_locked_in,
  input wire signed [PW-1:0] phase_offset_in,
  output reg [1:0] active_ref_out,
  output reg [1:0] loop_state_out,
  output reg signed [PW-1:0] phase_buildout_out,
  output reg slew_active_out,
  output reg irq_out
);

  // ****************************************
  // Synchronisers and validation
  // ****************************************
  reg [N-1:0] flag_meta;
  reg [N-1:0] flag_sync;
  reg [1:0] pin_meta;
  reg [1:0] pin_sync;
  reg [15:0] ctrl;
  reg [15:0] prio;
  reg [15:0] vtime;
  reg [15:0] slew;
  reg [15:0] fgrp;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  wire [N-1:0] valid;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_meta <= {N{1'b1}};
      flag_sync <= {N{1'b1}};
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      flag_meta <= monitor_flag_in;
      flag_sync <= flag_meta;
      pin_meta <= select_pins_in;
      pin_sync <= pin_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_val
      rss_validator #(.CW(16)) u_val (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .flag_in(flag_sync[gi]),
        .vtime_in(vtime),
        .valid_out(valid[gi])
      );
    end
  endgenerate

  // ****************************************
  // Priority choice
  // ****************************************
  // Lower priority field value wins; strict compare keeps lower index on ties
  function [2:0] best_valid;
    input [3:0] v;
    input [7:0] p;
    integer i;
    reg [1:0] bp;
    reg found;
    begin
      bp = 2'h3;
      found = 1'b0;
      best_valid = 3'h0;
      for (i = 0; i < 4; i = i + 1) begin
        if (v[i] && (!found || p[2*i +: 2] < bp)) begin // RULE18
          found = 1'b1;
          bp = p[2*i +: 2];
          best_valid = {1'b1, i[1:0]};
        end
      end
    end
  endfunction

  wire [1:0] mode = ctrl[`RSS_CTRL_MODE_LSB +: 2];
  wire hist_ok = ctrl[`RSS_CTRL_HIST_VALID];
  wire [1:0] man_choice = ctrl[`RSS_CTRL_PIN_SEL] ? pin_sync :
    ctrl[`RSS_CTRL_MAN_LSB +: 2]; // RULE3
  wire [2:0] best = best_valid(valid, prio[7:0]);
  // Monitors tuned to gapping keep a gapped input valid and tracked
  wire cur_valid = valid[active_ref_out]; // RULE15
  wire man_valid = valid[man_choice];

  // ****************************************
  // Selection state machine
  // ****************************************
  reg [1:0] next_ref;
  reg [1:0] next_state;
  always @* begin
    next_ref = active_ref_out;
    next_state = loop_state_out;
    case (mode)
      `RSS_MODE_AUTO_REV: begin
        if (best[2]) begin
          next_ref = best[1:0]; // RULE1
          next_state = `RSS_ST_TRACK;
        end else begin
          next_state = hist_ok ? `RSS_ST_HOLD : `RSS_ST_FREE;
        end
      end
      `RSS_MODE_AUTO_NREV: begin
        if (loop_state_out == `RSS_ST_TRACK && cur_valid) begin
          next_ref = active_ref_out; // RULE2
        end else if (best[2]) begin
          next_ref = best[1:0];
          next_state = `RSS_ST_TRACK;
        end else begin
          next_state = hist_ok ? `RSS_ST_HOLD : `RSS_ST_FREE;
        end
      end
      `RSS_MODE_MAN_FALL: begin
        if (man_valid) begin
          next_ref = man_choice; // RULE4 RULE7
          next_state = `RSS_ST_TRACK;
        end else if (best[2]) begin
          next_ref = best[1:0]; // RULE4
          next_state = `RSS_ST_TRACK;
        end else begin
          next_state = hist_ok ? `RSS_ST_HOLD : `RSS_ST_FREE; // RULE5
        end
      end
      `RSS_MODE_MAN_HOLD: begin
        next_ref = man_choice;
        if (man_valid) begin
          next_state = `RSS_ST_TRACK; // RULE7
        end else begin
          next_state = hist_ok ? `RSS_ST_HOLD : `RSS_ST_FREE; // RULE6
        end
      end
      default: begin
        next_state = `RSS_ST_FREE;
      end
    endcase
  end

  // ****************************************
  // Hitless switchover and phase slew
  // ****************************************
  wire switching = (next_state == `RSS_ST_TRACK) &&
    ((next_ref != active_ref_out) || (loop_state_out != `RSS_ST_TRACK));
  wire new_switch = (next_ref != active_ref_out) &&
    (loop_state_out == `RSS_ST_TRACK);
  // Frequency group labels: same label means equal or integer related
  wire freq_locked = new_switch &&
    (fgrp[2*next_ref +: 2] == fgrp[2*active_ref_out +: 2]); // RULE10
  // Pulse-per-second inputs cannot be switched hitlessly with zero-delay sync
  wire hitless_ok = ctrl[`RSS_CTRL_HITLESS] &&
    !(ctrl[`RSS_CTRL_PPS] && ctrl[`RSS_CTRL_ZDS]); // RULE13
  wire slew_en = ctrl[`RSS_CTRL_SLEW_EN];
  wire [7:0] step_lim = slew[7:0];
  wire [7:0] step_int = slew[15:8];
  reg [7:0] step_cnt;
  wire signed [PW-1:0] lim_p = {{(PW-8){1'b0}}, step_lim};
  wire signed [PW-1:0] lim_n = -lim_p;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_ref_out <= 2'h0;
      loop_state_out <= `RSS_ST_FREE;
      phase_buildout_out <= {PW{1'b0}};
      slew_active_out <= 1'b0;
      step_cnt <= 8'h00;
    end else begin
      active_ref_out <= next_ref;
      loop_state_out <= next_state;
      if (switching) begin
        if (!hitless_ok) begin
          phase_buildout_out <= {PW{1'b0}}; // RULE8
          slew_active_out <= 1'b0;
        end else if (freq_locked || !new_switch) begin
          // Absorb the step; acquisition entry starts from the measured one
          phase_buildout_out <= phase_offset_in; // RULE9
          slew_active_out <= slew_en; // RULE12
        end else begin
          phase_buildout_out <= phase_offset_in;
          slew_active_out <= 1'b1; // RULE12
        end
        step_cnt <= 8'h00;
      end else if (slew_active_out) begin
        if (phase_buildout_out == {PW{1'b0}}) begin
          slew_active_out <= 1'b0;
        end else if (step_cnt >= step_int) begin
          step_cnt <= 8'h00;
          // Bounded step keeps the output phase transient small
          if (phase_buildout_out > lim_p) begin
            phase_buildout_out <= phase_buildout_out - lim_p; // RULE11
          end else if (phase_buildout_out < lim_n) begin
            phase_buildout_out <= phase_buildout_out + lim_p; // RULE11
          end else begin
            phase_buildout_out <= {PW{1'b0}};
          end
        end else begin
          step_cnt <= step_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // Registers and interrupts
  // ****************************************
  wire [3:0] irq_evt;
  assign irq_evt[`RSS_IRQ_SWITCH] = new_switch;
  assign irq_evt[`RSS_IRQ_HOLD] = (next_state == `RSS_ST_HOLD) &&
    (loop_state_out != `RSS_ST_HOLD);
  assign irq_evt[`RSS_IRQ_FREE] = (next_state == `RSS_ST_FREE) &&
    (loop_state_out != `RSS_ST_FREE);
  assign irq_evt[`RSS_IRQ_INVALID] = (loop_state_out == `RSS_ST_TRACK) &&
    !cur_valid;
  wire wr_irq = reg_wr_in && (reg_addr_in == `RSS_REG_IRQ_STAT);

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= `RSS_CTRL_RESET;
      prio <= `RSS_PRIO_RESET;
      vtime <= `RSS_VTIME_RESET;
      slew <= `RSS_SLEW_RESET;
      fgrp <= `RSS_FGRP_RESET;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq_out <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `RSS_REG_CTRL: ctrl <= reg_wdata_in;
          `RSS_REG_PRIO: prio <= reg_wdata_in;
          `RSS_REG_VTIME: vtime <= reg_wdata_in;
          `RSS_REG_SLEW: slew <= reg_wdata_in;
          `RSS_REG_FGRP: fgrp <= reg_wdata_in;
          `RSS_REG_IRQ_MASK: irq_mask <= reg_wdata_in[3:0];
          default: ctrl <= ctrl;
        endcase
      end
      // Set wins over write-one-to-clear in the same cycle
      irq_stat <= (irq_stat & ~(wr_irq ? reg_wdata_in[3:0] : 4'h0)) |
        irq_evt;
      irq_out <= |(irq_stat & irq_mask);
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `RSS_REG_CTRL: reg_rdata_out <= ctrl;
          `RSS_REG_PRIO: reg_rdata_out <= prio;
          `RSS_REG_VTIME: reg_rdata_out <= vtime;
          `RSS_REG_SLEW: reg_rdata_out <= slew;
          `RSS_REG_FGRP: reg_rdata_out <= fgrp;
          `RSS_REG_STAT: reg_rdata_out <= {6'h00, slew_active_out,
            loop_locked_in, loop_state_out, active_ref_out, valid};
          `RSS_REG_IRQ_STAT: reg_rdata_out <= {12'h000, irq_stat};
          `RSS_REG_IRQ_MASK: reg_rdata_out <= {12'h000, irq_mask};
          `RSS_REG_BUILDOUT: reg_rdata_out <= phase_buildout_out[15:0];
          default: reg_rdata_out <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// File: rss_select_assertions.sv
// Port-level checker for the reference selection block.
// Assumes the register map of rss_regs.vh; bound at the foot of this file.
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_select_assertions #(
  parameter N = 4,
  parameter PW = 16
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire [N-1:0] monitor_flag_in,
  input wire [1:0] active_ref_out,
  input wire [1:0] loop_state_out,
  input wire signed [PW-1:0] phase_buildout_out,
  input wire slew_active_out,
  input wire irq_out
);
  // Shadows of host writes, rebuilt from the port traffic
  reg [15:0] ctrl;
  reg [15:0] mask;
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= 16'h0000;
      mask <= 16'h0000;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `RSS_REG_CTRL)
        ctrl <= reg_wdata_in;
      if (reg_addr_in == `RSS_REG_IRQ_MASK)
        mask <= reg_wdata_in;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_rdata_idle: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 16'h0000) else $error("read data outside slot");
  // Flag path is two sync flops plus one edge each for valid and select
  a_leave_bad: assert property ((loop_state_out == `RSS_ST_TRACK &&
    monitor_flag_in[active_ref_out] && $stable(active_ref_out))[*6] |=>
    loop_state_out != `RSS_ST_TRACK || $changed(active_ref_out))
    else $error("still tracking a flagged input");
  a_man_hold: assert property ((ctrl[1:0] == `RSS_MODE_MAN_HOLD &&
    !ctrl[`RSS_CTRL_PIN_SEL] && $stable(ctrl))[*3] |->
    active_ref_out == ctrl[3:2]) else $error("holdover left the choice");
  a_hitless_off: assert property ($changed(active_ref_out) &&
    !ctrl[`RSS_CTRL_HITLESS] |-> ##[0:1] phase_buildout_out == 0)
    else $error("buildout kept with hitless off");
  a_slew_done: assert property ($fell(slew_active_out) |->
    phase_buildout_out == 0) else $error("slew ended short of zero");
  a_irq_quiet: assert property ((mask == 16'h0000)[*2] |-> !irq_out)
    else $error("interrupt while fully masked");
  a_hold_hist: assert property (loop_state_out == `RSS_ST_HOLD &&
    $past(loop_state_out) != `RSS_ST_HOLD |->
    $past(ctrl[`RSS_CTRL_HIST_VALID])) else $error("holdover, no history");
  a_free_hist: assert property (loop_state_out == `RSS_ST_FREE &&
    $past(loop_state_out) == `RSS_ST_TRACK |->
    !$past(ctrl[`RSS_CTRL_HIST_VALID])) else $error("free-run with history");
endmodule
bind rss_select rss_select_assertions #(.N(N), .PW(PW)) chk (.core_clk_in,
  .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .monitor_flag_in, .active_ref_out, .loop_state_out,
  .phase_buildout_out, .slew_active_out, .irq_out);

// File: rss_ref_model.sv
// Reference sources and host selection pins facing the block.
// Assumes the bench commands which sources are faulty and the pin choice.
`timescale 1ns/1ps
module rss_ref_model #(
  parameter signed [15:0] OFFS = 16'sh0123
) (
  input wire core_clk_in,
  input wire [3:0] bad_in,
  input wire [1:0] choice_in,
  input wire locked_in,
  output reg [3:0] monitor_flag_out,
  output reg [1:0] select_pins_out,
  output wire signed [15:0] phase_offset_out
);
  // Sources share one frequency, so the offset between them is fixed
  assign phase_offset_out = OFFS;
  initial begin
    monitor_flag_out = 4'hF;
    select_pins_out = 2'h0;
  end
  always @(posedge core_clk_in) begin
    // Thresholds sit above gap widths: only real faults raise flags
    monitor_flag_out <= bad_in;
    // Pins only move once the loop reports lock
    if (locked_in)
      select_pins_out <= choice_in;
  end
endmodule

// File: rss_select_test.sv
// Self-checking bench for the reference selection block.
// Assumes the checker and partner model files are compiled before it.
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_select_test;
  localparam signed [15:0] OFFS = 16'sh0123;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg locked = 1'b0;
  reg [3:0] bad = 4'hF;
  reg [1:0] pin_ch = 2'h0;
  wire [15:0] rdata;
  wire [3:0] flags;
  wire [1:0] pins;
  wire signed [15:0] offs;
  wire signed [15:0] bo;
  wire [1:0] aref;
  wire [1:0] lst;
  wire slew;
  wire irq;
  integer n_errors = 0;
  integer checks = 0;
  integer k;
  rss_ref_model #(.OFFS(OFFS)) src (.core_clk_in(clk), .bad_in(bad),
    .choice_in(pin_ch), .locked_in(locked), .monitor_flag_out(flags),
    .select_pins_out(pins), .phase_offset_out(offs));
  rss_select #(.N(4), .PW(16)) DUT (.core_clk_in(clk), .rst_b_in(rst_b),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .monitor_flag_in(flags),
    .select_pins_in(pins), .loop_locked_in(locked),
    .phase_offset_in(offs), .active_ref_out(aref), .loop_state_out(lst),
    .phase_buildout_out(bo), .slew_active_out(slew), .irq_out(irq));
  initial forever #25 clk = ~clk;
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
    end
  endtask
  task sel(input [1:0] r, input [1:0] s);
    cmp({12'h0, aref, lst}, {12'h0, r, s});
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, input [15:0] e, input [15:0] m);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp(rdata & m, e);
    end
  endtask
  task flag(input [3:0] v);
    begin
      @(posedge clk);
      bad <= v;
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // Bounded wait for a new selection; the flag path is about 14 cycles
  task wait_ref(input [1:0] e);
    begin
      #1;
      for (k = 0; k < 40 && aref !== e; k = k + 1)
        @(posedge clk) #1;
      cmp({14'h0, aref}, {14'h0, e});
    end
  endtask
  task sw(input [15:0] c, input [15:0] e);
    begin
      wr_reg(`RSS_REG_CTRL, c);
      flag(4'h2);
      wait_ref(2'h2);
      step(10);
      cmp(bo, e);
      rd_reg(`RSS_REG_BUILDOUT, e, 16'hFFFF);
      flag(4'h0);
      wait_ref(2'h1);
    end
  endtask
  task t_regs;
    begin
      rd_reg(`RSS_REG_CTRL, 16'h0000, 16'hFFFF);
      rd_reg(`RSS_REG_PRIO, 16'hE4E4, 16'hFFFF);
      rd_reg(`RSS_REG_VTIME, 16'h0010, 16'hFFFF);
      rd_reg(`RSS_REG_SLEW, 16'h1004, 16'hFFFF);
      rd_reg(`RSS_REG_FGRP, 16'h0000, 16'hFFFF);
      wr_reg(4'hF, 16'hFFFF);
      rd_reg(4'hF, 16'h0000, 16'hFFFF);
    end
  endtask
  task t_auto;
    begin
      wr_reg(`RSS_REG_VTIME, 16'h0008);
      wr_reg(`RSS_REG_PRIO, 16'h0097);
      wr_reg(`RSS_REG_CTRL, 16'h0020);
      flag(4'h0);
      step(5);
      cmp({15'h0, lst === `RSS_ST_TRACK}, 16'h0000);
      wait_ref(2'h1);
      flag(4'h2);
      wait_ref(2'h2);
      flag(4'h0);
      step(5);
      cmp({14'h0, aref}, 16'h0002);
      wait_ref(2'h1);
      wr_reg(`RSS_REG_CTRL, 16'h0021);
      flag(4'h2);
      wait_ref(2'h2);
      flag(4'h0);
      step(30);
      sel(2'h2, `RSS_ST_TRACK);
    end
  endtask
  task t_manual;
    begin
      wr_reg(`RSS_REG_IRQ_STAT, 16'h000F);
      wr_reg(`RSS_REG_IRQ_MASK, 16'h0002);
      pin_ch <= 2'h3;
      wr_reg(`RSS_REG_CTRL, 16'h0032);
      wait_ref(2'h3);
      flag(4'h8);
      wait_ref(2'h1);
      cmp({15'h0, irq}, 16'h0000);
      flag(4'hF);
      step(20);
      cmp({14'h0, lst}, `RSS_ST_HOLD);
      cmp({15'h0, irq}, 16'h0001);
      rd_reg(`RSS_REG_IRQ_STAT, 16'h000B, 16'hFFFF);
      rd_reg(`RSS_REG_STAT, 16'h0150, 16'hFFFF);
      wr_reg(`RSS_REG_IRQ_MASK, 16'h0000);
      step(2);
      cmp({15'h0, irq}, 16'h0000);
      wr_reg(`RSS_REG_IRQ_MASK, 16'h0002);
      step(2);
      cmp({15'h0, irq}, 16'h0001);
      wr_reg(`RSS_REG_IRQ_STAT, 16'h0002);
      step(2);
      cmp({15'h0, irq}, 16'h0000);
      flag(4'h7);
      wait_ref(2'h3);
      wr_reg(`RSS_REG_CTRL, 16'h000E);
      flag(4'hF);
      step(20);
      cmp({14'h0, lst}, `RSS_ST_FREE);
      wr_reg(`RSS_REG_CTRL, 16'h002B);
      flag(4'h0);
      wait_ref(2'h2);
      flag(4'h4);
      step(20);
      sel(2'h2, `RSS_ST_HOLD);
      flag(4'h0);
      step(20);
      sel(2'h2, `RSS_ST_TRACK);
    end
  endtask
  task t_hitless;
    begin
      sw(16'h0020, 16'h0000);
      sw(16'h0060, OFFS);
      sw(16'h0360, 16'h0000);
      sw(16'h0260, OFFS);
      wr_reg(`RSS_REG_SLEW, 16'h0240);
      wr_reg(`RSS_REG_CTRL, 16'h00E0);
      flag(4'h2);
      wait_ref(2'h2);
      cmp({15'h0, slew}, 16'h0001);
      for (k = 0; k < 100 && slew !== 1'b0; k = k + 1)
        @(posedge clk) #1;
      // Five steps of at most 0x40, each after a three-cycle interval
      cmp(k[15:0], 16'h0010);
      cmp(bo, 16'h0000);
      wr_reg(`RSS_REG_FGRP, 16'h0004);
      wr_reg(`RSS_REG_CTRL, 16'h0060);
      flag(4'h0);
      wait_ref(2'h1);
      cmp({15'h0, slew}, 16'h0001);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #(4000 * 50);
    n_errors = n_errors + 1;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    locked <= 1'b1;
    t_regs;
    t_auto;
    t_manual;
    t_hitless;
    finish_test;
  end
endmodule
